// ### panel_pkg.sv
// What this block does
// RULE1 - Nonzero duration starts countdown when key switches on
// RULE2 - Running countdown blinks that function's indicator
// RULE3 - Function on without timer lights indicator steadily
// RULE4 - Countdown reaching zero switches function off
// RULE5 - Durations held and shown as hours, minutes
// RULE6 - Each up/down edit step is fifteen minutes
// RULE7 - Duration capped at eight hours, no higher step
// RULE8 - Duration stored only on second accept press; a bus write to REG_DURATION also stores it
// RULE9 - Blower lock defaults to disabled
// RULE10 - Enabled lock needs matching three-stroke sequence
// RULE11 - No click for first two strokes
// RULE12 - Lock offers none plus seven patterns
// RULE13 - Lock pattern committed only on second accept; a bus write to REG_LOCK also sets it
// RULE14 - Status shows only running timers with remaining time
// RULE15 - Menu selection wraps in both directions
// RULE16 - Zero duration runs untimed, indicator steady
// RULE17 - Wrong stroke discards sequence, blower stays off
// RULE18 - Countdowns step on common one-second tick
package panel_pkg;

  // ****************************************************************
  // Geometry and keys
  // ****************************************************************
  localparam int NUM_FUNC = 2;
  localparam int NUM_KEYS = 7;
  localparam int KEY_LIGHT = 0;
  localparam int KEY_OUTLET = 1;
  localparam int KEY_BLOWER = 2;
  localparam int KEY_HIDDEN = 3;
  localparam int KEY_UP = 4;
  localparam int KEY_DOWN = 5;
  localparam int KEY_ACCEPT = 6;
  localparam int ADDR_W = 8;
  localparam int REM_W = 15;
  localparam int LOCK_LEN = 3;

  // ****************************************************************
  // Durations and timing
  // ****************************************************************
  localparam int MIN_PER_STEP = 15;
  localparam int SECS_PER_STEP = MIN_PER_STEP * 60;
  localparam int MAX_HOURS = 8;
  localparam logic [5:0] STEP_MAX = 6'(MAX_HOURS * 60 / MIN_PER_STEP);
  localparam logic [1:0] STEPS_PER_HOUR_LOG2 = 2'h2;
  localparam int TICK_PERIOD_S = 1;
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_S * CLK_FREQ_HZ;

  // ****************************************************************
  // Register map, fields and reset values
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_DURATION = 8'h04;
  localparam logic [ADDR_W-1:0] REG_LOCK = 8'h08;
  localparam logic [ADDR_W-1:0] REG_REMAIN = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_MENU = 8'h10;
  localparam logic [ADDR_W-1:0] REG_HHMM = 8'h14;
  localparam int DUR_FIELD_STRIDE = 8;
  localparam int REM_FIELD_STRIDE = 16;
  localparam int HHMM_FIELD_STRIDE = 16;
  localparam int STAT_RUN_LSB = 4;
  localparam int STAT_CNT_LSB = 8;
  localparam int MENU_EDIT_BIT = 4;
  localparam int MENU_VAL_LSB = 8;
  localparam logic [5:0] DUR_RESET = 6'h00;
  localparam logic [2:0] LOCK_NONE = 3'h0;
  localparam logic [2:0] LOCK_RESET = LOCK_NONE;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ITEM_LIGHT, ITEM_OUTLET, ITEM_LOCK} menu_item_t;

endpackage

// ### key_sync.sv
// ****************************************************************
// Key synchroniser and press detector
// ****************************************************************
module key_sync
  import panel_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [panel_pkg::NUM_KEYS-1:0] key_raw,
  output logic [panel_pkg::NUM_KEYS-1:0] key_press
);

  logic [NUM_KEYS-1:0] meta_q;
  logic [NUM_KEYS-1:0] sync_q;
  logic [NUM_KEYS-1:0] prev_q;

  // Two flops per key, then one more for the rising edge
  for (genvar k = 0; k < NUM_KEYS; k++)
  begin : g_key
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        meta_q[k] <= 1'b0;
        sync_q[k] <= 1'b0;
        prev_q[k] <= 1'b0;
      end
      else
      begin
        meta_q[k] <= key_raw[k];
        sync_q[k] <= meta_q[k];
        prev_q[k] <= sync_q[k];
      end
    end
    assign key_press[k] = sync_q[k] & ~prev_q[k];
  end

endmodule

// ### panel_timer_lock.sv
// ****************************************************************
// Auto-off timers, menu editing and blower key lock
// ****************************************************************
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
module panel_timer_lock
  import panel_pkg::*;
#(
  parameter int TICK_LEN = panel_pkg::TICK_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [panel_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [panel_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic key_light,
  input wire logic key_outlet,
  input wire logic key_blower,
  input wire logic key_hidden,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic accept_key,
  output logic [panel_pkg::NUM_FUNC-1:0] func_on,
  output logic [panel_pkg::NUM_FUNC-1:0] func_led,
  output logic blower_on,
  output logic click
);

  import panel_pkg::*;

  logic [NUM_KEYS-1:0] key_p;
  logic [23:0] tick_cnt_q;
  logic tick_q;
  logic blink_q;
  logic [5:0] dur_q [NUM_FUNC];
  logic [REM_W-1:0] rem_q [NUM_FUNC];
  logic [NUM_FUNC-1:0] on_q;
  logic [NUM_FUNC-1:0] led_q;
  logic [NUM_FUNC-1:0] running;
  logic [2:0] lock_q;
  logic [1:0] stroke_cnt_q;
  logic blower_q;
  logic click_q;
  menu_item_t sel_q;
  logic editing_q;
  logic [5:0] edit_val_q;
  logic [5:0] cur_val;
  logic commit;
  logic stroke_bit;
  logic stroke_ok;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic wr_fire;
  logic [31:0] rd_data;
  logic rd_hit;

  // ****************************************************************
  // Key inputs
  // ****************************************************************
  key_sync u_keys (
    .aclk(aclk),
    .aresetn(aresetn),
    .key_raw({accept_key, key_down, key_up, key_hidden, key_blower, key_outlet, key_light}),
    .key_press(key_p)
  );

  // ****************************************************************
  // One-second tick and blink phase
  // ****************************************************************
  // All timers share this tick so remaining times stay in step
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b0;
      blink_q <= 1'b0;
    end
    else if (tick_cnt_q == 24'(TICK_LEN - 1)) // [RULE18]
    begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b1;
      blink_q <= ~blink_q;
    end
    else
    begin
      tick_cnt_q <= tick_cnt_q + 24'h000001;
      tick_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Timed functions
  // ****************************************************************
  assign commit = key_p[KEY_ACCEPT] & editing_q;
  assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;

  for (genvar i = 0; i < NUM_FUNC; i++)
  begin : g_func
    assign running[i] = on_q[i] & (rem_q[i] != '0);

    // Key toggles the function; a zero duration runs untimed
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        on_q[i] <= 1'b0;
        rem_q[i] <= '0;
      end
      else if (key_p[i])
      begin
        on_q[i] <= ~on_q[i];
        rem_q[i] <= on_q[i] ? '0 : REM_W'(dur_q[i] * SECS_PER_STEP); // [RULE1] [RULE16]
      end
      else if (running[i] && tick_q)
      begin
        if (rem_q[i] == REM_W'(1))
          on_q[i] <= 1'b0; // [RULE4]
        rem_q[i] <= rem_q[i] - REM_W'(1); // [RULE18]
      end
    end

    // Blink while counting, steady when untimed
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        led_q[i] <= 1'b0;
      else
        led_q[i] <= on_q[i] & (~running[i] | blink_q); // [RULE2] [RULE3] [RULE16]
    end

    // Duration: menu commit first, else a bus write clamped to the cap
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        dur_q[i] <= DUR_RESET;
      else if (commit && sel_q == menu_item_t'(i)) // [RULE8]
        dur_q[i] <= edit_val_q;
      else if (wr_fire && wr_addr_q == REG_DURATION && wr_strb_q[i])
      begin
        if (wr_data_q[i*DUR_FIELD_STRIDE +: 6] > STEP_MAX)
          dur_q[i] <= STEP_MAX; // [RULE7]
        else
          dur_q[i] <= wr_data_q[i*DUR_FIELD_STRIDE +: 6];
      end
    end
  end

  // ****************************************************************
  // Menu navigation and value editing
  // ****************************************************************
  always_comb
  begin
    unique case (sel_q)
      ITEM_LIGHT: cur_val = dur_q[0];
      ITEM_OUTLET: cur_val = dur_q[1];
      ITEM_LOCK: cur_val = {3'h0, lock_q};
      default: cur_val = 6'h00;
    endcase
  end

  // Durations saturate; the lock choice cycles through all eight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sel_q <= ITEM_LIGHT;
      editing_q <= 1'b0;
      edit_val_q <= 6'h00;
    end
    else if (key_p[KEY_ACCEPT])
    begin
      editing_q <= ~editing_q; // [RULE8] [RULE13]
      if (!editing_q)
        edit_val_q <= cur_val;
    end
    else if (key_p[KEY_UP])
    begin
      if (!editing_q)
        sel_q <= (sel_q == ITEM_LOCK) ? ITEM_LIGHT : menu_item_t'(sel_q + 2'h1); // [RULE15]
      else if (sel_q == ITEM_LOCK)
        edit_val_q <= {3'h0, edit_val_q[2:0] + 3'h1}; // [RULE12] [RULE13]
      else if (edit_val_q < STEP_MAX)
        edit_val_q <= edit_val_q + 6'h01; // [RULE6] [RULE7]
    end
    else if (key_p[KEY_DOWN])
    begin
      if (!editing_q)
        sel_q <= (sel_q == ITEM_LIGHT) ? ITEM_LOCK : menu_item_t'(sel_q - 2'h1); // [RULE15]
      else if (sel_q == ITEM_LOCK)
        edit_val_q <= {3'h0, edit_val_q[2:0] - 3'h1}; // [RULE12]
      else if (edit_val_q != 6'h00)
        edit_val_q <= edit_val_q - 6'h01; // [RULE6]
    end
  end

  // Lock choice; zero means no lock and is the reset value
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lock_q <= LOCK_RESET; // [RULE9]
    else if (commit && sel_q == ITEM_LOCK)
      lock_q <= edit_val_q[2:0]; // [RULE13]
    else if (wr_fire && wr_addr_q == REG_LOCK && wr_strb_q[0])
      lock_q <= wr_data_q[2:0];
  end

  // ****************************************************************
  // Blower key and hidden key sequence
  // ****************************************************************
  // Pattern bits, first stroke in the top bit: blower is 0, hidden is 1
  assign stroke_bit = ~key_p[KEY_BLOWER];
  assign stroke_ok = stroke_bit == lock_q[2'(LOCK_LEN - 1) - stroke_cnt_q];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      blower_q <= 1'b0;
      stroke_cnt_q <= 2'h0;
      click_q <= 1'b0;
    end
    else
    begin
      click_q <= 1'b0;
      if (key_p[KEY_BLOWER] || key_p[KEY_HIDDEN])
      begin
        if (blower_q)
        begin
          // Turning off is never locked
          stroke_cnt_q <= 2'h0;
          if (key_p[KEY_BLOWER])
          begin
            blower_q <= 1'b0;
            click_q <= 1'b1;
          end
        end
        else if (lock_q == LOCK_NONE)
        begin
          if (key_p[KEY_BLOWER])
          begin
            blower_q <= 1'b1; // [RULE9]
            click_q <= 1'b1;
          end
        end
        else if (!stroke_ok)
          stroke_cnt_q <= 2'h0; // [RULE17]
        else if (stroke_cnt_q == 2'(LOCK_LEN - 1))
        begin
          blower_q <= 1'b1; // [RULE10]
          click_q <= 1'b1; // [RULE11]
          stroke_cnt_q <= 2'h0;
        end
        else
          stroke_cnt_q <= stroke_cnt_q + 2'h1; // [RULE11]
      end
      else if (key_p != '0)
        click_q <= 1'b1;
    end
  end

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  // Address and data are taken independently; one write in flight
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      wr_addr_q <= '0;
      wr_data_q <= 32'h00000000;
      wr_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awready_q <= 1'b0;
        wr_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wready_q <= 1'b0;
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (wr_addr_q[ADDR_W-1:2] <= REG_HHMM[ADDR_W-1:2] && wr_addr_q[1:0] == 2'h0) ?
                   RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Read decode; an idle timer reads back zero remaining time
  always_comb
  begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      REG_STATUS:
        rd_data = {22'h0, stroke_cnt_q, 2'h0, running, 1'b0, blower_q, on_q}; // [RULE14]
      REG_DURATION:
        rd_data = {18'h0, dur_q[1], 2'h0, dur_q[0]};
      REG_LOCK:
        rd_data = {29'h0, lock_q};
      REG_REMAIN:
        rd_data = {1'b0, rem_q[1], 1'b0, rem_q[0]}; // [RULE14]
      REG_MENU:
        rd_data = {18'h0, edit_val_q, 3'h0, editing_q, 2'h0, sel_q};
      REG_HHMM:
        // Hours in the low byte, minutes in the next, per function
        for (int f = 0; f < NUM_FUNC; f++)
        begin
          rd_data[f*HHMM_FIELD_STRIDE +: 8] = 8'(dur_q[f] >> STEPS_PER_HOUR_LOG2); // [RULE5]
          rd_data[f*HHMM_FIELD_STRIDE+8 +: 8] = 8'(dur_q[f][1:0] * MIN_PER_STEP); // [RULE5]
        end
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign func_on = on_q;
  assign func_led = led_q;
  assign blower_on = blower_q;
  assign click = click_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TIMER_START: assert property ( // [RULE1]
    key_p[0] && !on_q[0] && dur_q[0] != 6'h00 |=> on_q[0] && rem_q[0] == REM_W'($past(dur_q[0]) * 900))
    else $error("light timer did not load on switch-on");
  AST_BLINK: assert property ( // [RULE2]
    running[0] |=> func_led[0] == $past(blink_q))
    else $error("running timer indicator not blinking");
  AST_STEADY: assert property ( // [RULE3]
    on_q[1] && rem_q[1] == '0 ##1 on_q[1] |-> func_led[1])
    else $error("untimed function indicator not steady");
  AST_EXPIRE: assert property ( // [RULE4]
    on_q[0] && rem_q[0] == REM_W'(1) && tick_q && !key_p[0] |=> !func_on[0] && rem_q[0] == '0)
    else $error("function stayed on at zero");
  AST_DECREMENT: assert property ( // [RULE18]
    running[0] && !tick_q && !key_p[0] |=> rem_q[0] == $past(rem_q[0]))
    else $error("timer moved without tick");
  AST_CAP: assert property ( // [RULE7]
    dur_q[0] <= 6'h20 && dur_q[1] <= 6'h20 && edit_val_q <= 6'h20)
    else $error("duration above eight hours");
  AST_STEP: assert property ( // [RULE6]
    editing_q && sel_q != ITEM_LOCK && key_p[KEY_UP] && !key_p[KEY_ACCEPT] && edit_val_q < 6'h20
    |=> edit_val_q == $past(edit_val_q) + 6'h01)
    else $error("edit step is not one quarter hour");
  AST_STORE_ONLY_ON_ACCEPT: assert property ( // [RULE8]
    $changed(dur_q[0]) |-> $past(commit) || $past(wr_fire))
    else $error("duration changed without accept");
  AST_LOCK_DEFAULT: assert property ( // [RULE9]
    $rose(aresetn) |-> lock_q == 3'h0)
    else $error("lock not disabled after reset");
  AST_SILENT_STROKES: assert property ( // [RULE11]
    lock_q != 3'h0 && !blower_q && key_p[KEY_HIDDEN] && stroke_cnt_q < 2'h2 |=> !click_q)
    else $error("click on early lock stroke");
  AST_BLOWER_GATE: assert property ( // [RULE10]
    $rose(blower_q) |-> $past(lock_q == 3'h0) || $past(stroke_cnt_q == 2'h2 && stroke_ok))
    else $error("blower started without matching sequence");
  AST_MISMATCH: assert property ( // [RULE17]
    !blower_q && lock_q != 3'h0 && (key_p[KEY_BLOWER] || key_p[KEY_HIDDEN]) && !stroke_ok
    |=> stroke_cnt_q == 2'h0 && !blower_q)
    else $error("wrong stroke not discarded");
  AST_WRAP: assert property ( // [RULE15]
    !editing_q && key_p[KEY_UP] && !key_p[KEY_ACCEPT] && sel_q == ITEM_LOCK |=> sel_q == ITEM_LIGHT)
    else $error("menu did not wrap");

  COV_TIMED_EXPIRY: cover property (running[0] ##1 !on_q[0]);
  COV_LOCK_OPEN: cover property (lock_q != 3'h0 && $rose(blower_q));
  COV_LOCK_EDIT: cover property (commit && sel_q == ITEM_LOCK);

endmodule

// ### panel_operator.sv
// ****************************************************************
// Front-panel operator model
// ****************************************************************
module panel_operator
(
  input wire logic aclk,
  output logic [panel_pkg::NUM_KEYS-1:0] keys
);
  timeunit 1ns;
  timeprecision 1ns;
  import panel_pkg::*;

  // Keys rest low, so reset never sees a held key
  initial keys = '0;

  // One stroke: held past the synchroniser, then a low gap before the next
  task automatic press(input int k);
    keys[k] <= 1'b1;
    repeat (3) @(posedge aclk);
    keys[k] <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
endmodule

// ### auto_off_timer_and_key_lock_bench.sv
// ****************************************************************
// Bench for the auto-off timers and blower key lock
// ****************************************************************
module auto_off_timer_and_key_lock_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import panel_pkg::*;

  logic aclk;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [NUM_KEYS-1:0] keys;
  logic [NUM_FUNC-1:0] func_on, func_led;
  logic blower_on, click;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_click = 0;
  int cyc = 0;

  // Clock at 10 MHz
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Click pulses and cycles counted off the design's edge
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (click === 1'b1) n_click <= n_click + 1;
  end

  // Short tick so a full countdown fits the run
  panel_timer_lock #(.TICK_LEN(20)) panel_timer_lock_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .key_light(keys[KEY_LIGHT]), .key_outlet(keys[KEY_OUTLET]),
    .key_blower(keys[KEY_BLOWER]), .key_hidden(keys[KEY_HIDDEN]), .key_up(keys[KEY_UP]),
    .key_down(keys[KEY_DOWN]), .accept_key(keys[KEY_ACCEPT]), .func_on(func_on),
    .func_led(func_led), .blower_on(blower_on), .click(click)
  );

  panel_operator panel_operator_i (.aclk(aclk), .keys(keys));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // ****************************************************************
  // Bus master tasks
  // ****************************************************************
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (50)
    begin
      @(posedge aclk);
      if (s_axi_bvalid === 1'b1 && aw_ok && w_ok)
      begin
        s_axi_bready <= 1'b0;
        check_resp("bresp", er, s_axi_bresp);
        // Let bready fall for one edge before a next call raises it
        @(posedge aclk);
        return;
      end
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    n_mismatch++;
    tally_and_finish();
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (50)
    begin
      @(posedge aclk);
      if (s_axi_rvalid === 1'b1)
      begin
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check_resp("rresp", er, s_axi_rresp);
        // Let rready fall for one edge before a next call raises it
        @(posedge aclk);
        return;
      end
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    n_mismatch++;
    tally_and_finish();
  endtask

  task automatic check_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, RESP_OKAY, d);
    check_val(what, exp, d);
  endtask

  // Three lock strokes, first stroke in bit 2, hidden key for a one
  task automatic enter(input logic [2:0] p);
    for (int i = 2; i >= 0; i--) panel_operator_i.press(p[i] ? KEY_HIDDEN : KEY_BLOWER);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    logic [31:0] d, r1, r2;
    logic [1:0] s0, s1;
    int t_on, c0, n;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset state and refused addresses
    check_reg("status", REG_STATUS, 32'h0000_0000);
    check_reg("duration", REG_DURATION, 32'h0000_0000);
    check_reg("lock", REG_LOCK, 32'h0000_0000);
    rd(8'h18, RESP_SLVERR, d);
    wr(8'h18, 32'h0000_0001, RESP_SLVERR);
    panel_operator_i.press(KEY_BLOWER);
    check_val("blower", 32'h1, {31'h0, blower_on});
    panel_operator_i.press(KEY_BLOWER);
    // Light timed for one step, outlet untimed
    wr(REG_DURATION, 32'h0000_0001, RESP_OKAY);
    check_reg("hhmm", REG_HHMM, 32'h0000_0f00);
    panel_operator_i.press(KEY_LIGHT);
    t_on = cyc;
    panel_operator_i.press(KEY_OUTLET);
    check_reg("status", REG_STATUS, 32'h0000_0013);
    s0 = 2'h0;
    s1 = 2'h0;
    repeat (60)
    begin
      @(posedge aclk);
      s0 = s0 | ~func_led;
      s1 = s1 | func_led;
    end
    check_val("blink", 32'h3, {30'h0, s0[0], s1[0]});
    check_val("steady", 32'h1, {30'h0, s0[1], s1[1]});
    // Read data captured exactly 200 cycles apart span exactly ten ticks
    rd(REG_REMAIN, RESP_OKAY, r1);
    repeat (197) @(posedge aclk);
    rd(REG_REMAIN, RESP_OKAY, r2);
    check_val("remain start", 32'h1, {31'h0, r1[14:0] <= 15'd900 && r1[14:0] >= 15'd880});
    check_val("remain step", 32'h0000_000a, 32'(r1[14:0]) - 32'(r2[14:0]));
    check_val("outlet remain", 32'h0, {17'h0, r1[30:16]});
    panel_operator_i.press(KEY_OUTLET);
    n = 0;
    while (func_on[0] !== 1'b0 && n < 19000)
    begin
      @(posedge aclk);
      n++;
    end
    check_val("expiry", 32'h1, {31'h0, (cyc - t_on) >= 17970 && (cyc - t_on) <= 18000});
    check_reg("remain", REG_REMAIN, 32'h0000_0000);
    // Ceiling and hours-minutes view
    wr(REG_DURATION, 32'h0000_2121, RESP_OKAY);
    check_reg("duration", REG_DURATION, 32'h0000_2020);
    check_reg("hhmm", REG_HHMM, 32'h0008_0008);
    wr(REG_DURATION, 32'h0000_001f, RESP_OKAY);
    check_reg("hhmm", REG_HHMM, 32'h0000_2d07);
    // Duration edit from the keypad, stored only on the second accept
    panel_operator_i.press(KEY_ACCEPT);
    check_reg("menu", REG_MENU, 32'h0000_1f10);
    panel_operator_i.press(KEY_UP);
    panel_operator_i.press(KEY_UP);
    check_reg("menu", REG_MENU, 32'h0000_2010);
    panel_operator_i.press(KEY_DOWN);
    check_reg("menu", REG_MENU, 32'h0000_1f10);
    panel_operator_i.press(KEY_UP);
    check_reg("duration", REG_DURATION, 32'h0000_001f);
    panel_operator_i.press(KEY_ACCEPT);
    check_reg("duration", REG_DURATION, 32'h0000_0020);
    // Menu wraps both ways
    panel_operator_i.press(KEY_DOWN);
    rd(REG_MENU, RESP_OKAY, d);
    check_val("menu item", 32'h2, {27'h0, d[4:0]});
    panel_operator_i.press(KEY_UP);
    rd(REG_MENU, RESP_OKAY, d);
    check_val("menu item", 32'h0, {27'h0, d[4:0]});
    panel_operator_i.press(KEY_DOWN);
    // Lock pattern chosen from the keypad
    panel_operator_i.press(KEY_ACCEPT);
    repeat (3) panel_operator_i.press(KEY_UP);
    check_reg("lock", REG_LOCK, 32'h0000_0000);
    panel_operator_i.press(KEY_ACCEPT);
    check_reg("lock", REG_LOCK, 32'h0000_0003);
    // Wrong second stroke, then a correct entry
    panel_operator_i.press(KEY_BLOWER);
    check_reg("status", REG_STATUS, 32'h0000_0100);
    panel_operator_i.press(KEY_BLOWER);
    check_reg("status", REG_STATUS, 32'h0000_0000);
    c0 = n_click;
    panel_operator_i.press(KEY_BLOWER);
    panel_operator_i.press(KEY_HIDDEN);
    check_val("click", 32'(c0), 32'(n_click));
    panel_operator_i.press(KEY_HIDDEN);
    check_val("click", 32'(c0 + 1), 32'(n_click));
    check_val("blower", 32'h1, {31'h0, blower_on});
    panel_operator_i.press(KEY_BLOWER);
    // Every pattern opens the lock
    for (int p = 1; p < 8; p++)
    begin
      wr(REG_LOCK, 32'(p), RESP_OKAY);
      enter(3'(p));
      check_val("blower", 32'h1, {31'h0, blower_on});
      panel_operator_i.press(KEY_BLOWER);
      check_val("blower off", 32'h0, {31'h0, blower_on});
    end
    tally_and_finish();
  end
endmodule
